// file: aic_host_model.sv
// host controller model: apb master driven by a command strobe
`timescale 1ns/1ns
module aic_host_model (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // command side
   input  wire logic        go,
   input  wire logic        wr,
   input  wire logic [11:0] addr,
   input  wire logic [31:0] wd,
   output logic             done,
   output logic [31:0]      rd,
   output logic             err,
   // apb master
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [11:0]      paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   // setup, then access held until pready is seen at a rising edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {psel, penable, pwrite, done, err} <= 5'h00;
         paddr  <= 12'h000;
         pwdata <= 32'h0000_0000;
         rd     <= 32'h0000_0000;
      end else begin
         done <= 1'b0;
         if (psel && penable && pready) begin
            psel    <= 1'b0;
            penable <= 1'b0;
            done    <= 1'b1;
            rd      <= prdata;
            err     <= pslverr;
            paddr   <= ~paddr;   // released bus shows no stale value
            pwdata  <= ~pwdata;
         end else if (psel) begin
            penable <= 1'b1;
         end else if (go && !done) begin
            psel   <= 1'b1;
            pwrite <= wr;
            paddr  <= addr;
            pwdata <= wd;
         end
      end
   end
endmodule : aic_host_model

// file: aic_lock_delay.sv
// module: post-calibration lock delay counter
`timescale 1ns/1ns
module aic_lock_delay (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // calibration engine
   input  wire logic        cal_start,
   input  wire logic        cal_done,
   input  wire logic        half_tick,
   // setting and result
   input  wire logic [15:0] delay,
   output logic             expired,
   output logic             busy
);

   aic_pkg::aic_ld_t q;
   aic_pkg::aic_ld_t d;

   // count half detector periods once calibration ends
   always_comb begin
      d = q;
      unique case (q.st)
         aic_pkg::LD_IDLE: begin
         end
         aic_pkg::LD_CAL: begin
            if (cal_done) begin
               d.st  = aic_pkg::LD_COUNT;
               d.cnt = 16'h0000;
            end
         end
         // R14 - count delay ticks
         aic_pkg::LD_COUNT: begin
            if (q.cnt == delay) begin
               d.st = aic_pkg::LD_LOCKED;
            end else if (half_tick) begin
               d.cnt = q.cnt + 16'h0001;
            end
         end
         aic_pkg::LD_LOCKED: begin
         end
      endcase
      // R15 - restart on new calibration
      if (cal_start) begin
         d.st  = aic_pkg::LD_CAL;
         d.cnt = 16'h0000;
      end
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '{st: aic_pkg::LD_IDLE, cnt: 16'h0000};
      end else begin
         q <= d;
      end
   end

   assign expired = (q.st == aic_pkg::LD_LOCKED);
   assign busy    = (q.st == aic_pkg::LD_CAL);

   a_delay_early: assert property ( // R14
      @(posedge pclk) disable iff (!presetn)
      (q.st == aic_pkg::LD_COUNT && q.cnt != delay && !cal_start)
      |=> q.st != aic_pkg::LD_LOCKED)
      else $error("lock delay expired before its count");

   a_delay_tick: assert property ( // R14
      @(posedge pclk) disable iff (!presetn)
      (q.st == aic_pkg::LD_COUNT && !half_tick && !cal_start)
      |=> $stable(q.cnt))
      else $error("lock delay moved without a tick");

   a_cal_restart: assert property ( // R15
      @(posedge pclk) disable iff (!presetn)
      cal_start |=> (q.st == aic_pkg::LD_CAL && q.cnt == 16'h0000))
      else $error("new calibration did not restart delay");

endmodule : aic_lock_delay

// file: aic_pkg.sv
// package: register map, reset values and state types of the config slice
package aic_pkg;

   // bus address width and word index field
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned IDX_W  = 10;

   // register indices, byte address is four times the index
   localparam logic [9:0] IDX_RSV_A  = 10'h035;
   localparam logic [9:0] IDX_RSV_B  = 10'h036;
   localparam logic [9:0] IDX_RSV_C  = 10'h037;
   localparam logic [9:0] IDX_RSV_D  = 10'h038;
   localparam logic [9:0] IDX_FIXED  = 10'h039;
   localparam logic [9:0] IDX_ALIGN  = 10'h03a;
   localparam logic [9:0] IDX_LOCK   = 10'h03b;
   localparam logic [9:0] IDX_DELAY  = 10'h03c;
   localparam logic [9:0] IDX_CTRL   = 10'h100;
   localparam logic [9:0] IDX_STATUS = 10'h101;
   localparam logic [9:0] IDX_IRQ_ST = 10'h102;
   localparam logic [9:0] IDX_IRQ_MK = 10'h103;

   // reset values
   localparam logic [15:0] RST_ZERO  = 16'h0000;
   localparam logic [15:0] RST_ALIGN = 16'h8001;
   localparam logic [15:0] RST_LOCK  = 16'h0001;
   localparam logic [15:0] RST_DELAY = 16'h03e8;

   // field positions of the align input word
   localparam int unsigned IGNORE_BIT = 15;
   localparam int unsigned HYST_BIT   = 14;
   localparam int unsigned LVL_HI     = 13;
   localparam int unsigned LVL_LO     = 12;
   localparam int unsigned FMT_HI     = 11;
   localparam int unsigned FMT_LO     = 9;
   localparam logic [1:0]  LVL_BAD    = 2'h3;

   // lock word, control, status and interrupt bits
   localparam int unsigned LOCK_TYPE_BIT = 0;
   localparam int unsigned CTRL_PHASE    = 0;
   localparam int unsigned CTRL_SRST     = 1;
   localparam int unsigned ST_LOCK       = 0;
   localparam int unsigned ST_BUSY       = 1;
   localparam int unsigned ST_VTUNE      = 2;
   localparam int unsigned IRQ_RISE      = 0;
   localparam int unsigned IRQ_FALL      = 1;
   localparam int unsigned IRQ_CAL       = 2;
   localparam int unsigned IRQ_W         = 3;

   // lock delay counter states
   typedef enum logic [1:0] {LD_IDLE, LD_CAL, LD_COUNT, LD_LOCKED}
      aic_ld_state_t;

   typedef struct packed {
      aic_ld_state_t st;
      logic [15:0]   cnt;
   } aic_ld_t;

   // register slice and bus state
   typedef struct packed {
      logic [3:0][15:0]   rsv;
      logic [15:0]        fixed_w;
      logic [15:0]        align_cfg;
      logic [15:0]        lock_cfg;
      logic [15:0]        delay_cfg;
      logic               phase_mode;
      logic [IRQ_W-1:0]   irq_stat;
      logic [IRQ_W-1:0]   irq_mask;
      logic               pready;
      logic               pslverr;
      logic [31:0]        prdata;
      logic               lock;
      logic               trig;
      logic               req;
   } aic_regs_t;

   localparam aic_regs_t AIC_REGS_RST = '{
      rsv: {4{RST_ZERO}}, fixed_w: RST_ZERO, align_cfg: RST_ALIGN,
      lock_cfg: RST_LOCK, delay_cfg: RST_DELAY, phase_mode: 1'b0,
      irq_stat: '0, irq_mask: '0, pready: 1'b0, pslverr: 1'b0,
      prdata: 32'h0000_0000, lock: 1'b0, trig: 1'b0, req: 1'b0};

endpackage : aic_pkg

// file: aic_sync.sv
// module: two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ns
module aic_sync #(
   parameter int unsigned W = 1
) (
   // clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // levels
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } aic_sync_t;

   aic_sync_t q;
   aic_sync_t d;

   // first stage feeds only the second
   always_comb begin
      d    = q;
      d.s1 = async_in;
      d.s2 = q.s1;
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign sync_out = q.s2;

endmodule : aic_sync

// file: aic_top.sv
// module: align input and lock indicator config slice with apb access
//
// Notes on behaviour
// R1 - host writes zero to reserved words and lock word bits 15..1.
// R2 - soft reset restores reserved words; host need not rewrite them.
// R3 - host writes 0x20 to the fixed word despite zero reset.
// R4 - host writes 1 into bits 8..0 of the align input word.
// R5 - ignore bit set and phase align off blocks both align pins.
// R6 - host keeps ignore bit set unless phase align mode is on.
// R7 - bit 14 enables high hysteresis on both align LVDS receivers.
// R8 - bits 13..12 pick bias: quarter, full, half Vin; 3 invalid.
// R9 - bits 11..9 pick CMOS or LVDS per pin, upper codes filter.
// R10 - align input word resets to 0x8001.
// R11 - lock word bit 0 picks indicator type, resets to one.
// R12 - type 0: lock high after calibration done and delay expired.
// R13 - type 1: also needs tuning voltage inside its window.
// R14 - delay field counts half detector periods after calibration.
// R15 - lock low during calibration; delay restarts on new calibration.
`timescale 1ns/1ns
module aic_top (
   // clock and reset
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   // apb slave
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [aic_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]                pwdata,
   output logic      [31:0]                prdata,
   output logic                            pready,
   output logic                            pslverr,
   // align input pins
   input  wire logic                       align_trigger_pin,
   input  wire logic                       sysref_request_pin,
   output logic                            align_trigger_out,
   output logic                            sysref_request_out,
   // receiver settings
   output logic                            align_input_hysteresis,
   output logic      [1:0]                 align_input_bias_level,
   output logic                            bias_level_invalid,
   output logic                            trigger_lvds,
   output logic                            request_lvds,
   output logic                            lvds_filter,
   // calibration engine and tuning monitor
   input  wire logic                       cal_start,
   input  wire logic                       cal_done,
   input  wire logic                       pd_half_tick,
   input  wire logic                       vtune_in_window,
   // lock indicator and interrupt
   output logic                            lock_out,
   output logic                            irq
);

   aic_pkg::aic_regs_t s_q;
   aic_pkg::aic_regs_t s_d;

   logic [2:0]                 sync_lv;
   logic                       trig_s;
   logic                       req_s;
   logic                       vtune_s;
   logic                       expired;
   logic                       cal_busy;
   logic [aic_pkg::IDX_W-1:0]  idx;
   logic                       setup;
   logic                       done;
   logic                       hit;
   logic [31:0]                rd;
   logic                       wr_en;
   logic                       pins_off;
   logic                       lock_d;
   logic [aic_pkg::IRQ_W-1:0]  ev;
   logic [2:0]                 fmt;

   // pin levels cross into the bus clock
   aic_sync #(
      .W(3)
   ) u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in ({vtune_in_window, sysref_request_pin, align_trigger_pin}),
      .sync_out (sync_lv)
   );

   assign trig_s  = sync_lv[0];
   assign req_s   = sync_lv[1];
   assign vtune_s = sync_lv[2];

   // delay after calibration before the calibration lock rises
   aic_lock_delay u_dly (
      .pclk      (pclk),
      .presetn   (presetn),
      .cal_start (cal_start),
      .cal_done  (cal_done),
      .half_tick (pd_half_tick),
      .delay     (s_q.delay_cfg),
      .expired   (expired),
      .busy      (cal_busy)
   );

   // bus phase decode
   assign idx   = paddr[aic_pkg::ADDR_W-1:2];
   assign setup = psel && !penable;
   assign done  = psel && penable && s_q.pready;
   assign wr_en = done && pwrite && !s_q.pslverr;

   // read mux and address hit
   always_comb begin
      hit = 1'b1;
      rd  = 32'h0000_0000;
      case (idx)
         aic_pkg::IDX_RSV_A:  rd[15:0] = s_q.rsv[0];
         aic_pkg::IDX_RSV_B:  rd[15:0] = s_q.rsv[1];
         aic_pkg::IDX_RSV_C:  rd[15:0] = s_q.rsv[2];
         aic_pkg::IDX_RSV_D:  rd[15:0] = s_q.rsv[3];
         aic_pkg::IDX_FIXED:  rd[15:0] = s_q.fixed_w;
         aic_pkg::IDX_ALIGN:  rd[15:0] = s_q.align_cfg;
         aic_pkg::IDX_LOCK:   rd[15:0] = s_q.lock_cfg;
         aic_pkg::IDX_DELAY:  rd[15:0] = s_q.delay_cfg;
         aic_pkg::IDX_CTRL:   rd[aic_pkg::CTRL_PHASE] = s_q.phase_mode;
         aic_pkg::IDX_STATUS: begin
            rd[aic_pkg::ST_LOCK]  = s_q.lock;
            rd[aic_pkg::ST_BUSY]  = cal_busy;
            rd[aic_pkg::ST_VTUNE] = vtune_s;
         end
         aic_pkg::IDX_IRQ_ST: rd[aic_pkg::IRQ_W-1:0] = s_q.irq_stat;
         aic_pkg::IDX_IRQ_MK: rd[aic_pkg::IRQ_W-1:0] = s_q.irq_mask;
         default:             hit = 1'b0;
      endcase
   end

   // R5 - pin ignore condition
   assign pins_off = s_q.align_cfg[aic_pkg::IGNORE_BIT] && !s_q.phase_mode;

   // R12 R13 - lock source by indicator type
   assign lock_d = s_q.lock_cfg[aic_pkg::LOCK_TYPE_BIT] ?
                   (expired && vtune_s) : expired;

   // lock edges and calibration end raise events
   assign ev[aic_pkg::IRQ_RISE] = lock_d && !s_q.lock;
   assign ev[aic_pkg::IRQ_FALL] = !lock_d && s_q.lock;
   assign ev[aic_pkg::IRQ_CAL]  = cal_done;

   // next state: bus answer, register writes, events
   always_comb begin
      s_d         = s_q;
      s_d.pready  = setup;
      s_d.pslverr = setup && !hit;
      s_d.prdata  = (setup && !pwrite && hit) ? rd : 32'h0000_0000;
      if (wr_en) begin
         case (idx)
            aic_pkg::IDX_RSV_A: s_d.rsv[0]    = pwdata[15:0];
            aic_pkg::IDX_RSV_B: s_d.rsv[1]    = pwdata[15:0];
            aic_pkg::IDX_RSV_C: s_d.rsv[2]    = pwdata[15:0];
            aic_pkg::IDX_RSV_D: s_d.rsv[3]    = pwdata[15:0];
            aic_pkg::IDX_FIXED: s_d.fixed_w   = pwdata[15:0];
            aic_pkg::IDX_ALIGN: s_d.align_cfg = pwdata[15:0];
            aic_pkg::IDX_LOCK:  s_d.lock_cfg  = pwdata[15:0];
            aic_pkg::IDX_DELAY: s_d.delay_cfg = pwdata[15:0];
            aic_pkg::IDX_IRQ_MK:
               s_d.irq_mask = pwdata[aic_pkg::IRQ_W-1:0];
            aic_pkg::IDX_CTRL: begin
               s_d.phase_mode = pwdata[aic_pkg::CTRL_PHASE];
               // R2 R10 R11 - soft reset restores the config words and phase mode, not the irq status or mask
               if (pwdata[aic_pkg::CTRL_SRST]) begin
                  s_d.rsv        = aic_pkg::AIC_REGS_RST.rsv;
                  s_d.fixed_w    = aic_pkg::AIC_REGS_RST.fixed_w;
                  s_d.align_cfg  = aic_pkg::AIC_REGS_RST.align_cfg;
                  s_d.lock_cfg   = aic_pkg::AIC_REGS_RST.lock_cfg;
                  s_d.delay_cfg  = aic_pkg::AIC_REGS_RST.delay_cfg;
                  s_d.phase_mode = 1'b0;
               end
            end
            default: begin
            end
         endcase
      end
      // read clears only the bits it returned, later events survive
      if (done && !pwrite && idx == aic_pkg::IDX_IRQ_ST) begin
         s_d.irq_stat = s_q.irq_stat & ~s_q.prdata[aic_pkg::IRQ_W-1:0];
      end
      s_d.irq_stat = s_d.irq_stat | ev;
      // R5 - gate pins while ignored
      s_d.trig = trig_s && !pins_off;
      s_d.req  = req_s && !pins_off;
      // R15 - expired is low while calibrating
      s_d.lock = lock_d;
   end

   // R10 R11 - power-up reset values
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= aic_pkg::AIC_REGS_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // bus and indicator outputs
   assign prdata             = s_q.prdata;
   assign pready             = s_q.pready;
   assign pslverr            = s_q.pslverr;
   assign align_trigger_out  = s_q.trig;
   assign sysref_request_out = s_q.req;
   assign lock_out           = s_q.lock;
   assign irq                = |(s_q.irq_stat & s_q.irq_mask);

   // R7 R8 R9 - receiver settings from the align word
   assign fmt = s_q.align_cfg[aic_pkg::FMT_HI:aic_pkg::FMT_LO];
   assign align_input_hysteresis = s_q.align_cfg[aic_pkg::HYST_BIT];
   assign align_input_bias_level =
      s_q.align_cfg[aic_pkg::LVL_HI:aic_pkg::LVL_LO];
   assign bias_level_invalid = (align_input_bias_level == aic_pkg::LVL_BAD);
   assign trigger_lvds = fmt[0];
   assign request_lvds = fmt[1];
   assign lvds_filter  = fmt[2] && (fmt[1:0] != 2'h0);

   a_pins_ignored: assert property ( // R5
      @(posedge pclk) disable iff (!presetn)
      (s_q.align_cfg[15] && !s_q.phase_mode)
      |=> (!align_trigger_out && !sysref_request_out))
      else $error("align pins passed while ignored");

   a_pins_pass: assert property ( // R5
      @(posedge pclk) disable iff (!presetn)
      (!s_q.align_cfg[15] || s_q.phase_mode)
      |=> (align_trigger_out == $past(trig_s)
           && sysref_request_out == $past(req_s)))
      else $error("align pin not passed when enabled");

   a_hyst_write: assert property ( // R7
      @(posedge pclk) disable iff (!presetn)
      (wr_en && idx == aic_pkg::IDX_ALIGN)
      |=> align_input_hysteresis == $past(pwdata[14]))
      else $error("hysteresis does not follow bit 14");

   a_bias_write: assert property ( // R8
      @(posedge pclk) disable iff (!presetn)
      (wr_en && idx == aic_pkg::IDX_ALIGN)
      |=> (align_input_bias_level == $past(pwdata[13:12])
           && bias_level_invalid == ($past(pwdata[13:12]) == 2'h3)))
      else $error("bias level does not follow bits 13..12");

   a_format_map: assert property ( // R9
      @(posedge pclk) disable iff (!presetn)
      (wr_en && idx == aic_pkg::IDX_ALIGN && pwdata[11:9] == 3'h4)
      |=> (!trigger_lvds && !request_lvds && !lvds_filter))
      else $error("format code 4 is not both cmos");

   a_format_filt: assert property ( // R9
      @(posedge pclk) disable iff (!presetn)
      (wr_en && idx == aic_pkg::IDX_ALIGN && pwdata[11:9] == 3'h6)
      |=> (!trigger_lvds && request_lvds && lvds_filter))
      else $error("format code 6 wrong");

   a_soft_reset: assert property ( // R10
      @(posedge pclk) disable iff (!presetn)
      (wr_en && idx == aic_pkg::IDX_CTRL && pwdata[1])
      |=> (s_q.align_cfg == 16'h8001 && s_q.rsv == '0))
      else $error("soft reset did not restore align word");

   a_type_reset: assert property ( // R11
      @(posedge pclk) disable iff (!presetn)
      (wr_en && idx == aic_pkg::IDX_CTRL && pwdata[1])
      |=> s_q.lock_cfg == 16'h0001 ##1 s_q.lock_cfg[0])
      else $error("lock type did not reset to one");

   a_lock_cal: assert property ( // R12
      @(posedge pclk) disable iff (!presetn)
      (!s_q.lock_cfg[0] ##1 lock_out) |-> $past(expired))
      else $error("type 0 lock without expired delay");

   a_lock_vtune: assert property ( // R13
      @(posedge pclk) disable iff (!presetn)
      (s_q.lock_cfg[0] && expired && !vtune_s) |=> !lock_out)
      else $error("type 1 lock with tuning out of window");

   a_low_in_cal: assert property ( // R15
      @(posedge pclk) disable iff (!presetn)
      cal_busy |=> !lock_out)
      else $error("lock high during calibration");

endmodule : aic_top

// file: align_input_lock_indicator_cfg_test.sv
// self-checking bench of the align input and lock indicator slice
`timescale 1ns/1ns
module align_input_lock_indicator_cfg_test;
   logic        pclk, presetn, go, wr, done, err, psel, penable, pwrite;
   logic        pready, pslverr, tp, sp, to, so, hy, bi, tl, rl, lf;
   logic        vt, lock_out, irq;
   logic [1:0]  bl;
   logic [2:0]  evt;
   logic [11:0] ha, paddr;
   logic [31:0] hd, rd, pwdata, prdata, seed;
   logic [9:0]  idx_t [8];
   logic [15:0] rst_t [8];
   int          fails, num_checks;

   aic_host_model u_host (.pclk(pclk), .presetn(presetn), .go(go),
      .wr(wr), .addr(ha), .wd(hd), .done(done), .rd(rd), .err(err),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   aic_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .align_trigger_pin(tp), .sysref_request_pin(sp),
      .align_trigger_out(to), .sysref_request_out(so),
      .align_input_hysteresis(hy), .align_input_bias_level(bl),
      .bias_level_invalid(bi), .trigger_lvds(tl), .request_lvds(rl),
      .lvds_filter(lf), .cal_start(evt[0]), .cal_done(evt[1]),
      .pd_half_tick(evt[2]), .vtune_in_window(vt), .lock_out(lock_out),
      .irq(irq));

   // clock, 4 ns period
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   // watchdog against a hung handshake
   initial begin
      #100000;
      fails++;
      conclude();
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   // expected receiver settings from an align input word
   function automatic logic [31:0] algn(input logic [31:0] v);
      algn = {25'h0, v[14], v[13:12], v[13:12] == 2'h3, v[9], v[10],
              v[11] && v[10:9] != 2'h0};
   endfunction : algn

   task automatic chk(input string s, input logic [31:0] seen,
                      input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", s, exp, seen);
      end
   endtask : chk

   task automatic settle(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask : settle

   task automatic acc(input logic w, input logic [9:0] x,
                      input logic [31:0] v);
      int n;
      n = 0;
      @(posedge pclk);
      go <= 1'b1;
      wr <= w;
      ha <= {x, 2'b00};
      hd <= v;
      @(posedge pclk);
      while (!done && n < 40) begin
         @(posedge pclk);
         n++;
      end
      go <= 1'b0;
      if (n == 40) chk("apb wait", 32'h0, 32'h1);
   endtask : acc

   task automatic rdchk(input logic [9:0] x, input logic [31:0] exp,
                        input string s);
      acc(1'b0, x, 32'h0000_0000);
      chk(s, rd, exp);
   endtask : rdchk

   // one-cycle pulses of start, done or tick
   task automatic ev(input logic [2:0] m);
      @(posedge pclk);
      evt <= m;
      @(posedge pclk);
      evt <= 3'b000;
   endtask : ev

   task automatic ticks(input int n);
      repeat (n) begin
         ev(3'b100);
         @(posedge pclk);
      end
   endtask : ticks

   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : conclude

   // main sequence
   initial begin
      int          i;
      logic [31:0] d;
      presetn = 1'b0;
      {go, wr, tp, sp, vt} = 5'h00;
      ha = 12'h000;
      hd = 32'h0000_0000;
      evt = 3'b000;
      seed = 32'h0001_0ba9;
      fails = 0;
      num_checks = 0;
      idx_t = '{aic_pkg::IDX_RSV_A, aic_pkg::IDX_RSV_B, aic_pkg::IDX_RSV_C,
                aic_pkg::IDX_RSV_D, aic_pkg::IDX_FIXED, aic_pkg::IDX_ALIGN,
                aic_pkg::IDX_LOCK, aic_pkg::IDX_DELAY};
      rst_t = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
                16'h8001, 16'h0001, 16'h03e8};
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      for (i = 0; i < 8; i++) begin
         rdchk(idx_t[i], {16'h0000, rst_t[i]}, "reset");
      end
      // random words, upper half reads zero, unmapped index refused
      for (i = 0; i < 8; i++) begin
         d = rnd();
         acc(1'b1, idx_t[i], d);
         rdchk(idx_t[i], {16'h0000, d[15:0]}, "rw");
      end
      acc(1'b0, 10'h03d, 32'h0000_0000);
      chk("slverr", {31'h0, err}, 32'h1);
      chk("unmapped", rd, 32'h0);
      $display("test registers finished");
      // soft reset restores the reserved and align words
      acc(1'b1, aic_pkg::IDX_CTRL, 32'h0000_0002);
      settle(2);
      for (i = 0; i < 4; i++) begin
         rdchk(idx_t[i], 32'h0000_0000, "srst");
      end
      rdchk(aic_pkg::IDX_ALIGN, 32'h0000_8001, "srst align");
      acc(1'b1, aic_pkg::IDX_FIXED, 32'h0000_0020);
      rdchk(aic_pkg::IDX_FIXED, 32'h0000_0020, "fixed");
      $display("test soft reset finished");
      // every format and bias code, low bits kept at one
      for (i = 0; i < 32; i++) begin
         d = rnd();
         d = {16'h0000, 1'b1, d[0], i[4:0], 9'h001};
         acc(1'b1, aic_pkg::IDX_ALIGN, d);
         settle(1);
         chk("align", {25'h0, hy, bl, bi, tl, rl, lf}, algn(d));
      end
      // pin gating for each ignore and phase align setting
      for (i = 0; i < 8; i++) begin
         acc(1'b1, aic_pkg::IDX_CTRL, {31'h0, i[1]});
         acc(1'b1, aic_pkg::IDX_ALIGN, {16'h0, i[0], 15'h0001});
         d = rnd();
         d = {30'h0, ~i[2], d[0]};
         @(posedge pclk);
         tp <= d[1];
         sp <= d[0];
         settle(6);
         chk("pins", {30'h0, to, so}, (i[0] && !i[1]) ? 32'h0 : d);
      end
      // ignore stays set with phase align off
      acc(1'b1, aic_pkg::IDX_CTRL, 32'h0000_0000);
      $display("test align inputs finished");
      // lock word upper bits zero, type 0, short delay
      acc(1'b1, aic_pkg::IDX_DELAY, 32'h0000_0005);
      acc(1'b1, aic_pkg::IDX_LOCK, 32'h0000_0000);
      ev(3'b001);
      settle(2);
      acc(1'b0, aic_pkg::IDX_STATUS, 32'h0000_0000);
      chk("busy", rd & 32'h2, 32'h2);
      ev(3'b010);
      settle(2);
      chk("irq masked", {31'h0, irq}, 32'h0);
      acc(1'b1, aic_pkg::IDX_IRQ_MK, 32'h0000_0007);
      settle(1);
      chk("irq set", {31'h0, irq}, 32'h1);
      rdchk(aic_pkg::IDX_IRQ_ST, 32'h0000_0004, "irq stat");
      settle(1);
      chk("irq clear", {31'h0, irq}, 32'h0);
      ticks(4);
      settle(6);
      chk("lock early", {31'h0, lock_out}, 32'h0);
      ticks(1);
      settle(6);
      chk("lock", {31'h0, lock_out}, 32'h1);
      ev(3'b001);
      settle(3);
      chk("lock in cal", {31'h0, lock_out}, 32'h0);
      // calibration restarted in mid count
      ev(3'b010);
      ticks(3);
      ev(3'b001);
      ev(3'b010);
      ticks(4);
      settle(6);
      chk("lock restart", {31'h0, lock_out}, 32'h0);
      ticks(1);
      settle(6);
      chk("lock again", {31'h0, lock_out}, 32'h1);
      // type 1 also needs the tuning voltage in window
      acc(1'b1, aic_pkg::IDX_LOCK, 32'h0000_0001);
      settle(3);
      chk("vtune low", {31'h0, lock_out}, 32'h0);
      @(posedge pclk);
      vt <= 1'b1;
      settle(6);
      chk("vtune high", {31'h0, lock_out}, 32'h1);
      @(posedge pclk);
      vt <= 1'b0;
      settle(6);
      chk("vtune gone", {31'h0, lock_out}, 32'h0);
      $display("test lock indicator finished");
      conclude();
   end
endmodule : align_input_lock_indicator_cfg_test
